// *** pkg/damas_pkg.sv ***
package damas_pkg;

   // Clock rate
   localparam int unsigned CLK_MHZ = 250;

   // Bus address layout, word address in 4k-word banks
   localparam int unsigned DAL_W = 18;
   localparam int unsigned WADDR_W = 17;
   localparam int unsigned ROW_LSB = 0;
   localparam int unsigned COL_LSB = 6;
   localparam int unsigned UPPER_ROW_BIT = 12;
   localparam int unsigned UPPER_COL_BIT = 13;
   localparam int unsigned BANK_LSB = 12;
   localparam int unsigned BANK_W = 5;
   localparam int unsigned MA_W = 7;
   localparam int unsigned RFCNT_W = 5;

   // Reserve window narrowing bits
   localparam int unsigned IO_BIT_2K = 11;
   localparam int unsigned IO_BIT_1K = 10;
   localparam int unsigned IO_BIT_512 = 9;

   // Timing in ns and derived cycle counts
   localparam int unsigned T_ROW_NS = 40;
   localparam int unsigned T_COL_NS = 40;
   localparam int unsigned T_RF_STEP_NS = 200;
   localparam int unsigned T_REFRESH_NS = 15000;
   localparam int unsigned ROW_CYC = (T_ROW_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned COL_CYC = (T_COL_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RF_STEP_CYC =
      (T_RF_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned REFRESH_CYC = (T_REFRESH_NS * CLK_MHZ) / 1000;
   localparam int unsigned TMR_W = 12;

   // Register map, byte addresses
   localparam logic [3:0] CFG_OFS = 4'h0;
   localparam logic [3:0] STAT_OFS = 4'h4;

   // Configuration field positions
   localparam int unsigned CFG_START_LSB = 0;
   localparam int unsigned CFG_STOP_LSB = 5;
   localparam int unsigned CFG_START_EN_BIT = 10;
   localparam int unsigned CFG_IO_LSB = 11;
   localparam int unsigned CFG_EXT_RF_BIT = 14;
   localparam int unsigned CFG_RPLY_EN_BIT = 15;
   localparam int unsigned CFG_W = 16;

   // Start 0k (compare off), stop 128k, 4k reserve, internal refresh
   localparam logic [15:0] CFG_RESET = 16'h03FF;

   typedef struct packed {
      logic rply_en;
      logic ext_rf;
      logic [2:0] io_sw;
      logic start_en;
      logic [4:0] stop_sw;
      logic [4:0] start_sw;
   } damas_cfg_t;

   typedef struct packed {
      logic pend;
      logic rf_act;
      logic select;
      logic [5:0] rf_addr;
   } damas_stat_t;

   typedef struct packed {
      logic [DAL_W-1:0] dal;
      logic bsync;
      logic ext_req;
      logic ext_rf_req;
      logic dc_ok;
      logic io_bank;
   } damas_pins_t;

endpackage

// *** core/damas_rfaddr.sv ***
`timescale 1ns/1ps
module damas_rfaddr (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic refresh_addr_select,
   input wire logic refresh_step_ack,
   output logic refresh_row_lsb,
   output logic [damas_pkg::RFCNT_W-1:0] rf_upper
);
   logic lsb_r;
   logic lsb_nxt;
   logic [damas_pkg::RFCNT_W-1:0] cnt_r;
   logic [damas_pkg::RFCNT_W-1:0] cnt_nxt;
   wire lsb_fall = refresh_addr_select & refresh_step_ack & lsb_r;

   // Held clear outside refresh, toggles per step ack
   assign lsb_nxt = !refresh_addr_select ? 1'b0 :
                    refresh_step_ack ? ~lsb_r : lsb_r;
   // Upper count steps once per completed row pair
   assign cnt_nxt = lsb_fall ? cnt_r + 5'h01 : cnt_r;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         lsb_r <= 1'b0;
         cnt_r <= 5'h00;
      end else begin
         lsb_r <= lsb_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign refresh_row_lsb = lsb_r;
   assign rf_upper = cnt_r;

   a_lsb_clear: assert property (@(posedge ref_clk)
      disable iff (!rstn) !refresh_addr_select |=> !lsb_r)
      else $error("refresh lsb not cleared outside refresh");
   a_cnt_step: assert property (@(posedge ref_clk)
      disable iff (!rstn) lsb_fall |=> cnt_r == $past(cnt_r) + 5'h01)
      else $error("refresh counter missed a pair");
endmodule

// *** core/damas_top.sv ***
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module damas_top (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [damas_pkg::DAL_W-1:0] bus_dal,
   input wire logic bus_sync,
   input wire logic bus_din,
   input wire logic bus_dout,
   input wire logic ext_refresh_request,
   input wire logic dc_power_ok,
   input wire logic io_bank_select,
   output logic [damas_pkg::MA_W-1:0] mem_addr,
   output logic row_select,
   output logic col_select,
   output logic refresh_addr_select,
   output logic refresh_step_ack,
   output logic refresh_row_lsb,
   output logic module_select,
   output logic refresh_reply
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_ROW, ST_COL, ST_EXT_END, ST_RF
   } damas_state_t;

   localparam int unsigned PIN_W = $bits(damas_pkg::damas_pins_t);

   // Carry of a + ~b: set when a is above b
   function automatic logic above5(input logic [4:0] a,
                                   input logic [4:0] b);
      logic [5:0] s;
      s = {1'b0, a} + {1'b0, ~b};
      return s[5];
   endfunction

   // Pin synchroniser
   damas_pkg::damas_pins_t pins_raw;
   logic [PIN_W-1:0] meta_r;
   logic [PIN_W-1:0] sync_r;
   damas_pkg::damas_pins_t pin;
   assign pins_raw = '{dal: bus_dal, bsync: bus_sync,
                       ext_req: bus_din | bus_dout,
                       ext_rf_req: ext_refresh_request,
                       dc_ok: dc_power_ok, io_bank: io_bank_select};
   assign pin = damas_pkg::damas_pins_t'(sync_r);

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= pins_raw;
         sync_r <= meta_r;
      end
   end

   // Configuration register
   logic [damas_pkg::CFG_W-1:0] cfg_r;
   logic [damas_pkg::CFG_W-1:0] cfg_nxt;
   damas_pkg::damas_cfg_t cfg;
   assign cfg = damas_pkg::damas_cfg_t'(cfg_r);

   // Wishbone slave, ack one cycle after strobe
   logic ack_r;
   logic [31:0] rdat_r;
   wire wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
   wire hit_cfg = {wb_adr_i[3:2], 2'b00} == damas_pkg::CFG_OFS;
   wire hit_stat = {wb_adr_i[3:2], 2'b00} == damas_pkg::STAT_OFS;
   wire wr_cfg = wb_req & wb_we_i & hit_cfg;
   damas_pkg::damas_stat_t stat;
   wire [31:0] rd_mux = hit_cfg ? {16'h0000, cfg_r} :
                        hit_stat ? {23'h000000, stat} : 32'h00000000;
   assign cfg_nxt = {wr_cfg & wb_sel_i[1] ? wb_dat_i[15:8] : cfg_r[15:8],
                     wr_cfg & wb_sel_i[0] ? wb_dat_i[7:0] : cfg_r[7:0]};

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ack_r <= 1'b0;
         rdat_r <= 32'h00000000;
         cfg_r <= damas_pkg::CFG_RESET;
      end else begin
         ack_r <= wb_req;
         rdat_r <= wb_req & ~wb_we_i ? rd_mux : rdat_r;
         cfg_r <= cfg_nxt;
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   // Address latch: open while sync low, held while high
   logic [damas_pkg::DAL_W-1:0] addr_r;
   logic bsync_d_r;
   wire sync_rise = pin.bsync & ~bsync_d_r;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         addr_r <= '0;
         bsync_d_r <= 1'b0;
      end else begin
         addr_r <= pin.bsync ? addr_r : pin.dal;
         bsync_d_r <= pin.bsync;
      end
   end

   // Word address sits on lines 01 and up
   wire [damas_pkg::WADDR_W-1:0] wa_l = addr_r[damas_pkg::DAL_W-1:1];
   wire [damas_pkg::WADDR_W-1:0] wa_s = pin.dal[damas_pkg::DAL_W-1:1];
   wire [damas_pkg::MA_W-1:0] row_addr =
      {wa_l[damas_pkg::UPPER_ROW_BIT], wa_l[damas_pkg::ROW_LSB +: 6]};
   wire [damas_pkg::MA_W-1:0] col_addr =
      {wa_l[damas_pkg::UPPER_COL_BIT], wa_l[damas_pkg::COL_LSB +: 6]};

   // Range decode on the address being latched
   wire [4:0] bank = wa_s[damas_pkg::BANK_LSB +: damas_pkg::BANK_W];
   // Bounds are (boundary/4k - 1): above start code means at or past start
   wire start_ok = ~cfg.start_en | above5(bank, cfg.start_sw);
   wire stop_out = above5(bank, cfg.stop_sw);
   // Each closed reserve switch routes one more address bit in
   wire io_excl = pin.io_bank
      & (~cfg.io_sw[0] | wa_s[damas_pkg::IO_BIT_2K])
      & (~cfg.io_sw[1] | wa_s[damas_pkg::IO_BIT_1K])
      & (~cfg.io_sw[2] | wa_s[damas_pkg::IO_BIT_512]);

   // Refresh request sources
   logic [damas_pkg::TMR_W-1:0] tmr_r;
   logic ext_rf_d_r;
   logic pend_r;
   damas_state_t state_r;
   damas_state_t state_nxt;
   wire tmr_done = tmr_r == 12'(damas_pkg::REFRESH_CYC - 1);
   wire int_evt = ~cfg.ext_rf & tmr_done;
   wire ext_evt = cfg.ext_rf & pin.ext_rf_req & ~ext_rf_d_r;
   wire rf_evt = int_evt | ext_evt;
   wire take_rf = state_r == ST_IDLE & pend_r;
   wire rf_starting = pend_r | state_r == ST_RF;
   wire sel_cond = start_ok & ~stop_out & ~rf_starting
                   & pin.dc_ok & ~io_excl;

   logic select_r;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tmr_r <= '0;
         ext_rf_d_r <= 1'b0;
         pend_r <= 1'b0;
         select_r <= 1'b0;
      end else begin
         tmr_r <= tmr_done | cfg.ext_rf ? '0 : tmr_r + 12'h001;
         ext_rf_d_r <= pin.ext_rf_req;
         // New request in the taking cycle is kept
         pend_r <= rf_evt | (pend_r & ~take_rf);
         // Select decided at sync rise, dropped with sync
         select_r <= sync_rise ? sel_cond : select_r & pin.bsync;
      end
   end
   assign module_select = select_r;

   // Cycle sequencer; refresh wins at idle, no preemption
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   wire [damas_pkg::RFCNT_W-1:0] rf_upper;
   wire ext_go = select_r & pin.ext_req;
   wire step_done = cnt_r == 8'(damas_pkg::RF_STEP_CYC - 1);
   wire row_done = cnt_r == 8'(damas_pkg::ROW_CYC - 1);
   wire col_done = cnt_r == 8'(damas_pkg::COL_CYC - 1);
   wire ack_w = state_r == ST_RF & step_done;
   wire pair_done = ack_w & refresh_row_lsb;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r + 8'h01;
      case (state_r)
         ST_IDLE: begin
            cnt_nxt = 8'h00;
            if (pend_r) begin
               state_nxt = ST_RF;
            end else if (ext_go) begin
               state_nxt = ST_ROW;
            end
         end
         ST_ROW: begin
            if (row_done) begin
               state_nxt = ST_COL;
               cnt_nxt = 8'h00;
            end
         end
         ST_COL: begin
            if (col_done) begin
               state_nxt = ST_EXT_END;
            end
         end
         ST_EXT_END: begin
            cnt_nxt = 8'h00;
            if (!pin.ext_req && !pin.bsync) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_RF: begin
            // Two steps, LSB low then high, one request
            if (step_done) begin
               cnt_nxt = 8'h00;
               if (refresh_row_lsb) begin
                  state_nxt = ST_IDLE;
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            cnt_nxt = 8'h00;
         end
      endcase
   end

   // At most one address source per state; none in idle, which holds the last address
   wire rf_sel_w = state_r == ST_RF;
   wire row_sel_w = state_r == ST_ROW;
   wire col_sel_w = state_r == ST_COL | state_r == ST_EXT_END;
   logic [damas_pkg::MA_W-1:0] mem_addr_r;
   wire [damas_pkg::MA_W-1:0] rf_addr = {1'b0, rf_upper, refresh_row_lsb};
   wire [damas_pkg::MA_W-1:0] ma_mux = rf_sel_w ? rf_addr :
                                       row_sel_w ? row_addr :
                                       col_sel_w ? col_addr : mem_addr_r;
   logic reply_r;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
         cnt_r <= 8'h00;
         mem_addr_r <= '0;
         reply_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         mem_addr_r <= ma_mux;
         reply_r <= pair_done & cfg.ext_rf & cfg.rply_en;
      end
   end

   // Refresh address generator
   damas_rfaddr u_rfaddr (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .refresh_addr_select(rf_sel_w),
      .refresh_step_ack(ack_w),
      .refresh_row_lsb(refresh_row_lsb),
      .rf_upper(rf_upper)
   );

   assign mem_addr = mem_addr_r;
   assign row_select = row_sel_w;
   assign col_select = col_sel_w;
   assign refresh_addr_select = rf_sel_w;
   assign refresh_step_ack = ack_w;
   assign refresh_reply = reply_r;
   assign stat = '{pend: pend_r, rf_act: rf_sel_w, select: select_r,
                   rf_addr: {rf_upper, refresh_row_lsb}};

   // Checks
   a_one_source: assert property (@(posedge ref_clk)
      disable iff (!rstn) $onehot0({rf_sel_w, row_sel_w, col_sel_w}))
      else $error("more than one address source enabled");
   a_row_drive: assert property (@(posedge ref_clk)
      disable iff (!rstn)
      row_sel_w & $past(row_sel_w) |-> mem_addr_r == $past(row_addr))
      else $error("row address not driven");
   a_col_drive: assert property (@(posedge ref_clk)
      disable iff (!rstn) state_r == ST_COL & $past(state_r) == ST_COL
      |-> mem_addr_r == $past(col_addr))
      else $error("column address not driven");
   a_latch_hold: assert property (@(posedge ref_clk)
      disable iff (!rstn) pin.bsync |=> addr_r == $past(addr_r))
      else $error("address latch moved while sync held");
   a_dual_rows: assert property (@(posedge ref_clk)
      disable iff (!rstn) $rose(rf_sel_w) |-> !refresh_row_lsb
      ##(damas_pkg::RF_STEP_CYC) refresh_row_lsb)
      else $error("refresh did not cover two rows");
   a_rf_len: assert property (@(posedge ref_clk)
      disable iff (!rstn) $rose(rf_sel_w) |-> rf_sel_w [*8])
      else $error("refresh select dropped early");
   a_sel_block: assert property (@(posedge ref_clk)
      disable iff (!rstn)
      sync_rise & (stop_out | io_excl | ~pin.dc_ok | pend_r) |=> !select_r)
      else $error("select taken while blocked");
   a_start_cmp: assert property (@(posedge ref_clk)
      disable iff (!rstn)
      sync_rise & cfg.start_en & bank <= cfg.start_sw |=> !select_r)
      else $error("select below start bound");
   a_timer: assert property (@(posedge ref_clk)
      disable iff (!rstn) int_evt |=> pend_r)
      else $error("timer expiry lost");
   a_reply: assert property (@(posedge ref_clk)
      disable iff (!rstn)
      reply_r |-> cfg.ext_rf & cfg.rply_en & $past(pair_done))
      else $error("refresh reply without cause");
   a_no_preempt: assert property (@(posedge ref_clk)
      disable iff (!rstn) state_r == ST_ROW |=> state_r != ST_RF)
      else $error("refresh cut into an external cycle");
   a_ma_hold: assert property (@(posedge ref_clk)
      disable iff (!rstn)
      !rf_sel_w & !row_sel_w & !col_sel_w |=> $stable(mem_addr_r))
      else $error("memory address moved with no source");
   a_rf_addr: assert property (@(posedge ref_clk)
      disable iff (!rstn)
      rf_sel_w & $past(rf_sel_w) |-> mem_addr_r == $past(rf_addr))
      else $error("refresh address not driven");
   a_sel_drop: assert property (@(posedge ref_clk)
      disable iff (!rstn) !pin.bsync |=> !select_r)
      else $error("select held after bus sync fell");
   a_ext_start: assert property (@(posedge ref_clk)
      disable iff (!rstn)
      state_r == ST_IDLE & ext_go & !pend_r |=> row_sel_w)
      else $error("external cycle not started");

   c_ext_cycle: cover property (@(posedge ref_clk) disable iff (!rstn)
      state_r == ST_COL ##1 state_r == ST_EXT_END);
   c_refresh: cover property (@(posedge ref_clk) disable iff (!rstn)
      pair_done);
   c_collide: cover property (@(posedge ref_clk) disable iff (!rstn)
      state_r == ST_IDLE & pend_r & ext_go);
   c_io_excl: cover property (@(posedge ref_clk) disable iff (!rstn)
      sync_rise & io_excl);
   c_ext_reply: cover property (@(posedge ref_clk) disable iff (!rstn)
      reply_r);
endmodule

// *** verif/damas_host.sv ***
`timescale 1ns/1ps
module damas_host (
   input wire logic ref_clk,
   output logic [damas_pkg::DAL_W-1:0] bus_dal,
   output logic bus_sync,
   output logic bus_din,
   output logic bus_dout,
   output logic ext_refresh_request
);
   initial begin
      bus_dal = '0;
      bus_sync = 1'b0;
      bus_din = 1'b0;
      bus_dout = 1'b0;
      ext_refresh_request = 1'b0;
   end

   // Word address on lines 17..1, line 0 unused
   task addr_phase(input logic [16:0] wa);
      @(posedge ref_clk);
      bus_dal <= {wa, 1'b0};
      // Address set up a cycle ahead, so the latch closes on it
      @(posedge ref_clk);
      bus_sync <= 1'b1;
   endtask

   // Address leaves the lines in the data phase; only the latch keeps it
   task data_req(input logic rd);
      repeat (4) @(posedge ref_clk);
      bus_dal <= ~bus_dal;
      bus_din <= rd;
      bus_dout <= !rd;
   endtask

   task end_cycle();
      @(posedge ref_clk);
      bus_din <= 1'b0;
      bus_dout <= 1'b0;
      bus_sync <= 1'b0;
      bus_dal <= ~bus_dal;
   endtask

   // Edge-detected by the board, so a short level is enough
   task ext_refresh();
      @(posedge ref_clk);
      ext_refresh_request <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ext_refresh_request <= 1'b0;
   endtask
endmodule

// *** verif/damas_top_tb.sv ***
`timescale 1ns/1ps
module damas_top_tb;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [damas_pkg::DAL_W-1:0] bus_dal;
   logic bus_sync, bus_din, bus_dout, ext_refresh_request;
   logic dc_power_ok = 1'b1;
   logic io_bank_select = 1'b0;
   logic [damas_pkg::MA_W-1:0] mem_addr;
   logic row_select, col_select, refresh_addr_select, refresh_step_ack;
   logic refresh_row_lsb, module_select, refresh_reply;
   logic [31:0] rd;
   int n_mismatch = 0;
   int comparisons = 0;
   int cyc_cnt = 0;

   always #2 ref_clk = ~ref_clk;

   damas_host host (.ref_clk(ref_clk), .bus_dal(bus_dal),
      .bus_sync(bus_sync), .bus_din(bus_din), .bus_dout(bus_dout),
      .ext_refresh_request(ext_refresh_request));

   damas_top DUT (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .bus_dal(bus_dal), .bus_sync(bus_sync),
      .bus_din(bus_din), .bus_dout(bus_dout),
      .ext_refresh_request(ext_refresh_request),
      .dc_power_ok(dc_power_ok), .io_bank_select(io_bank_select),
      .mem_addr(mem_addr), .row_select(row_select),
      .col_select(col_select), .refresh_addr_select(refresh_addr_select),
      .refresh_step_ack(refresh_step_ack),
      .refresh_row_lsb(refresh_row_lsb), .module_select(module_select),
      .refresh_reply(refresh_reply));

   task close_out();
      $display("Counts: %0d mismatches, %0d comparisons", n_mismatch,
               comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Ceiling well above the two refresh intervals plus the idle wait
   always @(posedge ref_clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         n_mismatch = n_mismatch + 1;
         close_out();
      end
   end

   task cmp32(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got 0x%h expected 0x%h", $time, got, exp);
      end
   endtask

   // Settled values: sample one ns after the edge
   task tick();
      @(posedge ref_clk);
      #1;
   endtask

   task wb(input logic we, input logic [3:0] adr, input logic [31:0] d,
           output logic [31:0] q);
      int n;
      n = 0;
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      // Ack one cycle after the taking edge
      cmp32(32'(n), 32'h2);
   endtask

   task t_regs();
      wb(1'b0, damas_pkg::CFG_OFS, 32'h0, rd);
      cmp32(rd, 32'h0000_03FF);
      wb(1'b1, 4'h8, 32'hFFFF_FFFF, rd);
      wb(1'b0, 4'h8, 32'h0, rd);
      cmp32(rd, 32'h0);
      wb(1'b0, damas_pkg::CFG_OFS, 32'h0, rd);
      cmp32(rd, 32'h0000_03FF);
      wb(1'b0, damas_pkg::STAT_OFS, 32'h0, rd);
      cmp32(rd, 32'h0);
      $display("t_regs done");
   endtask

   task sel_case(input logic [15:0] cfg, input logic [16:0] wa,
                 input logic io, input logic pwr, input logic exp);
      wb(1'b1, damas_pkg::CFG_OFS, {16'h0, cfg}, rd);
      io_bank_select <= io;
      dc_power_ok <= pwr;
      host.addr_phase(wa);
      repeat (6) tick();
      cmp32(32'(module_select), 32'(exp));
      host.end_cycle();
      repeat (6) tick();
   endtask

   task t_range();
      sel_case(16'h0480, 17'h00000, 1'b0, 1'b1, 1'b0);
      sel_case(16'h0480, 17'h01000, 1'b0, 1'b1, 1'b1);
      sel_case(16'h0480, 17'h04FFF, 1'b0, 1'b1, 1'b1);
      sel_case(16'h0480, 17'h05000, 1'b0, 1'b1, 1'b0);
      sel_case(16'h0480, 17'h01000, 1'b0, 1'b0, 1'b0);
      sel_case(16'h03FF, 17'h00000, 1'b0, 1'b1, 1'b1);
      sel_case(16'h03FF, 17'h1F000, 1'b1, 1'b1, 1'b0);
      sel_case(16'h03FF, 17'h1F000, 1'b0, 1'b1, 1'b1);
      sel_case(16'h0BFF, 17'h1F000, 1'b1, 1'b1, 1'b1);
      sel_case(16'h0BFF, 17'h1F800, 1'b1, 1'b1, 1'b0);
      sel_case(16'h1BFF, 17'h1FC00, 1'b1, 1'b1, 1'b0);
      sel_case(16'h3BFF, 17'h1FC00, 1'b1, 1'b1, 1'b1);
      sel_case(16'h3BFF, 17'h1FE00, 1'b1, 1'b1, 1'b0);
      io_bank_select <= 1'b0;
      $display("t_range done");
   endtask

   task t_mux();
      logic [16:0] wa;
      int n;
      wa = 17'h0A5B3;
      wb(1'b1, damas_pkg::CFG_OFS, 32'h0000_03FF, rd);
      host.addr_phase(wa);
      host.data_req(1'b1);
      n = 0;
      while (row_select !== 1'b1 && n < 40) begin tick(); n++; end
      repeat (4) tick();
      cmp32(32'(mem_addr), 32'({wa[12], wa[5:0]}));
      cmp32(32'({row_select, col_select, refresh_addr_select}),
            32'h4);
      n = 0;
      while (col_select !== 1'b1 && n < 40) begin tick(); n++; end
      repeat (4) tick();
      cmp32(32'(mem_addr), 32'({wa[13], wa[11:6]}));
      cmp32(32'({row_select, col_select, refresh_addr_select}),
            32'h2);
      host.end_cycle();
      n = 0;
      while (col_select !== 1'b0 && n < 40) begin tick(); n++; end
      cmp32(32'(col_select), 32'h0);
      $display("t_mux done");
   endtask

   task rf_pass(input logic [4:0] up, input logic rep_exp);
      int n;
      int acks;
      int reps;
      n = 0;
      acks = 0;
      reps = 0;
      while (refresh_addr_select !== 1'b1 && n < 4000) begin tick(); n++; end
      cmp32(32'(refresh_row_lsb), 32'h0);
      tick();
      tick();
      cmp32(32'(mem_addr), {25'h0, 1'b0, up, 1'b0});
      n = 0;
      while (refresh_addr_select === 1'b1 && n < 300) begin
         tick();
         n++;
         if (refresh_reply === 1'b1) reps++;
         if (refresh_step_ack === 1'b1) begin
            acks++;
            if (acks == 1) begin
               tick();
               tick();
               cmp32(32'(refresh_row_lsb), 32'h1);
               cmp32(32'(mem_addr), {25'h0, 1'b0, up, 1'b1});
            end
         end
      end
      repeat (4) begin
         tick();
         if (refresh_reply === 1'b1) reps++;
      end
      cmp32(32'(acks), 32'h2);
      cmp32(32'(refresh_row_lsb), 32'h0);
      cmp32(32'(reps), 32'(rep_exp));
   endtask

   task t_int_refresh();
      int n;
      rf_pass(5'd0, 1'b0);
      n = 0;
      while (refresh_addr_select !== 1'b1 && n < 4000) begin tick(); n++; end
      cmp32(32'(n >= 3600 && n <= 3760), 32'h1);
      rf_pass(5'd1, 1'b0);
      $display("t_int_refresh done");
   endtask

   task t_ext_refresh();
      int n;
      wb(1'b1, damas_pkg::CFG_OFS, 32'h0000_C3FF, rd);
      host.ext_refresh();
      host.addr_phase(17'h01000);
      repeat (4) tick();
      cmp32(32'(module_select), 32'h0);
      host.end_cycle();
      rf_pass(5'd2, 1'b1);
      wb(1'b1, damas_pkg::CFG_OFS, 32'h0000_43FF, rd);
      host.ext_refresh();
      rf_pass(5'd3, 1'b0);
      n = 0;
      while (refresh_addr_select !== 1'b1 && n < 3900) begin tick(); n++; end
      cmp32(32'(refresh_addr_select), 32'h0);
      $display("t_ext_refresh done");
   endtask

   initial begin
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      t_regs();
      t_range();
      t_mux();
      t_int_refresh();
      t_ext_refresh();
      close_out();
   end
endmodule
